/* hw/cief_defs.svh */
// Offsets, field positions, reset values, constants and status bits of the interrupt enable and flag block
`ifndef CIEF_DEFS_SVH
`define CIEF_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CIEF_OFF_INTCTL     12'h000
`define CIEF_OFF_PERIPH_EN  12'h004
`define CIEF_OFF_PFLAG      12'h008
`define CIEF_OFF_EDGESEL    12'h00c
`define CIEF_OFF_PCPINS     12'h010
`define CIEF_OFF_ISTAT      12'h014
`define CIEF_OFF_IENA       12'h018
`define CIEF_OFF_ICLR       12'h01c
`define CIEF_OFF_VECTOR     12'h020

// ****************************************************************
// Control register bit positions
// ****************************************************************
`define CIEF_BIT_GLOBAL_EN  7
`define CIEF_BIT_GROUP_EN   6
`define CIEF_BIT_TOVE       5
`define CIEF_BIT_EXTE       4
`define CIEF_BIT_PCHE       3
`define CIEF_BIT_TOVF       2
`define CIEF_BIT_EXTF       1
`define CIEF_BIT_PCHF       0

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define CIEF_RST_INTCTL     8'h00
`define CIEF_RST_PERIPH_EN  8'h00
`define CIEF_IRQ_VECTOR     13'h0004
`define CIEF_APB_ZERO       32'h0000_0000

// Status bits of the summary interrupt register
`define CIEF_ST_TAKEN       0
`define CIEF_ST_EXT         1
`define CIEF_ST_PCH         2
`define CIEF_ST_TOV         3
`define CIEF_ST_W           4

`endif

/* hw/cief_pkg.sv */
// Types shared by the interrupt enable and flag block
package cief_pkg;

    // Rise and fall pair of the external pin, used inside the pin-event unit
    typedef struct packed {
        logic       ext_rise;
        logic       ext_fall;
    } cief_edge_t;

endpackage : cief_pkg

/* hw/cief_pin_if.sv */
// Interface carrying pin samples and detected events between the top and the pin-event unit
interface cief_pin_if #(parameter int PORT_W = 8);
    logic              ext_pin;
    logic              ext_edge_sel;
    logic [PORT_W-1:0] port_pins;
    logic [PORT_W-1:0] pin_enables;
    logic              ext_event;
    logic              port_event;

    modport top  (output ext_pin, output ext_edge_sel, output port_pins,
                  output pin_enables, input ext_event, input port_event);
    modport unit (input ext_pin, input ext_edge_sel, input port_pins,
                  input pin_enables, output ext_event, output port_event);
endinterface : cief_pin_if

/* hw/cief_pin_events.sv */
// Edge and change detection for the external pin and the monitored port pins
module cief_pin_events
    import cief_pkg::*;
#(
    parameter int PORT_W = 8
)(
    input  wire logic  clk,
    input  wire logic  reset,
    cief_pin_if.unit   pins
);

    logic              ext_ff;
    logic              nxt_ext;
    logic [PORT_W-1:0] port_ff;
    logic [PORT_W-1:0] nxt_port;
    logic              primed_ff;
    logic              nxt_primed;
    cief_edge_t        edge_s;

    // Previous-sample comparison; first cycle after reset is only a priming sample
    always_comb
    begin
        nxt_ext           = pins.ext_pin;
        nxt_port          = pins.port_pins;
        nxt_primed        = 1'b1;
        edge_s.ext_rise   = primed_ff && pins.ext_pin && !ext_ff;
        edge_s.ext_fall   = primed_ff && !pins.ext_pin && ext_ff;
        // Selected edge only
        pins.ext_event    = pins.ext_edge_sel ? edge_s.ext_rise : edge_s.ext_fall;
        // Changes on unmonitored pins are masked out
        pins.port_event   = primed_ff && |((pins.port_pins ^ port_ff) & pins.pin_enables);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ext_ff    <= 1'b0;
            port_ff   <= '0;
            primed_ff <= 1'b0;
        end
        else
        begin
            ext_ff    <= nxt_ext;
            port_ff   <= nxt_port;
            primed_ff <= nxt_primed;
        end
    end

endmodule : cief_pin_events

/* hw/cief_core_irq.sv */
// Interrupt enable and flag logic with APB register access and core request generation
//
// Local design decisions: the address map and the APB interface to the registers.
`include "cief_defs.svh"
module cief_core_irq
    import cief_pkg::*;
#(
    parameter int PORT_W = 8
)(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              timer_rollover,
    input  wire logic              ext_pin,
    input  wire logic [PORT_W-1:0] port_pins,
    input  wire logic [7:0]        periph_flags,
    input  wire logic              irq_ack,
    output logic                   core_irq_req,
    output logic                   irq_taken,
    output logic [12:0]            irq_vector,
    output logic                   irq
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [7:0]            intctl_ff;
    logic [7:0]            nxt_intctl;
    logic [7:0]            periph_en_ff;
    logic [7:0]            nxt_periph_en;
    logic                  edgesel_ff;
    logic                  nxt_edgesel;
    logic [PORT_W-1:0]     pcpins_ff;
    logic [PORT_W-1:0]     nxt_pcpins;
    logic [`CIEF_ST_W-1:0] istat_ff;
    logic [`CIEF_ST_W-1:0] nxt_istat;
    logic [`CIEF_ST_W-1:0] iena_ff;
    logic [`CIEF_ST_W-1:0] nxt_iena;
    logic [31:0]           prdata_ff;
    logic [31:0]           nxt_prdata;
    logic                  pslverr_ff;
    logic                  nxt_pslverr;
    logic                  wr_en;
    logic                  rd_en;
    logic                  hit;
    logic                  group_req;
    logic                  core_src;
    logic [`CIEF_ST_W-1:0] st_evt;

    cief_pin_if #(.PORT_W(PORT_W)) pin_bus ();

    // ****************************************************************
    // Pin event detection
    // ****************************************************************
    assign pin_bus.ext_pin      = ext_pin;
    assign pin_bus.ext_edge_sel = edgesel_ff;
    assign pin_bus.port_pins    = port_pins;
    assign pin_bus.pin_enables  = pcpins_ff;

    cief_pin_events #(.PORT_W(PORT_W)) u_pins (
        .clk   (clk),
        .reset (reset),
        .pins  (pin_bus)
    );

    // Access completes in the first access-phase cycle
    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == `CIEF_OFF_INTCTL)  || (a == `CIEF_OFF_PERIPH_EN) ||
                    (a == `CIEF_OFF_PFLAG)   || (a == `CIEF_OFF_EDGESEL) ||
                    (a == `CIEF_OFF_PCPINS)  || (a == `CIEF_OFF_ISTAT) ||
                    (a == `CIEF_OFF_IENA)    || (a == `CIEF_OFF_ICLR)  ||
                    (a == `CIEF_OFF_VECTOR);
    endfunction : is_mapped

    assign pready  = 1'b1;
    assign hit     = is_mapped(paddr);
    assign wr_en   = psel && penable && pwrite && hit;
    assign rd_en   = psel && penable && !pwrite;

    // ****************************************************************
    // Request to the core
    // ****************************************************************
    // Peripheral sources only pass under the group enable
    assign group_req = intctl_ff[`CIEF_BIT_GROUP_EN] && |(periph_en_ff & periph_flags);
    assign core_src  = (intctl_ff[`CIEF_BIT_TOVE] && intctl_ff[`CIEF_BIT_TOVF])
                    || (intctl_ff[`CIEF_BIT_EXTE] && intctl_ff[`CIEF_BIT_EXTF])
                    || (intctl_ff[`CIEF_BIT_PCHE] && intctl_ff[`CIEF_BIT_PCHF]);
    // Global enable gates all sources
    assign core_irq_req = intctl_ff[`CIEF_BIT_GLOBAL_EN] && (core_src || group_req);
    // Core acknowledge only counts while a request stands
    assign irq_taken    = core_irq_req && irq_ack;
    assign irq_vector   = `CIEF_IRQ_VECTOR;
    assign prdata       = prdata_ff;
    assign pslverr      = pslverr_ff;
    assign irq          = |(istat_ff & iena_ff);

    // ****************************************************************
    // Register next state
    // ****************************************************************
    // Hardware sets win over same-cycle software clears so no event is lost
    always_comb
    begin
        nxt_intctl  = intctl_ff;
        nxt_periph_en = periph_en_ff;
        nxt_edgesel = edgesel_ff;
        nxt_pcpins  = pcpins_ff;
        nxt_iena    = iena_ff;
        nxt_istat   = istat_ff;
        nxt_prdata  = prdata_ff;
        nxt_pslverr = 1'b0;
        if (wr_en)
        begin
            unique case (paddr)
                `CIEF_OFF_INTCTL:  nxt_intctl  = pwdata[7:0];
                `CIEF_OFF_PERIPH_EN: nxt_periph_en = pwdata[7:0];
                `CIEF_OFF_EDGESEL: nxt_edgesel = pwdata[0];
                `CIEF_OFF_PCPINS:  nxt_pcpins  = pwdata[PORT_W-1:0];
                `CIEF_OFF_IENA:    nxt_iena    = pwdata[`CIEF_ST_W-1:0];
                `CIEF_OFF_ICLR:    nxt_istat   = istat_ff & ~pwdata[`CIEF_ST_W-1:0];
                default:           nxt_intctl  = intctl_ff;
            endcase
        end
        // Taking the interrupt drops the global enable
        if (irq_taken)
            nxt_intctl[`CIEF_BIT_GLOBAL_EN] = 1'b0;
        // Flags set regardless of the interrupt enables (port change only on pins set in PCPINS), and stay until written to zero
        if (timer_rollover)
            nxt_intctl[`CIEF_BIT_TOVF] = 1'b1;
        if (pin_bus.ext_event)
            nxt_intctl[`CIEF_BIT_EXTF] = 1'b1;
        if (pin_bus.port_event)
            nxt_intctl[`CIEF_BIT_PCHF] = 1'b1;
        st_evt = '0;
        st_evt[`CIEF_ST_TAKEN] = irq_taken;
        st_evt[`CIEF_ST_EXT]   = pin_bus.ext_event;
        st_evt[`CIEF_ST_PCH]   = pin_bus.port_event;
        st_evt[`CIEF_ST_TOV]   = timer_rollover;
        nxt_istat = nxt_istat | st_evt;
        if (psel && penable)
            nxt_pslverr = !hit;
        if (rd_en)
        begin
            nxt_prdata = `CIEF_APB_ZERO;
            unique case (paddr)
                `CIEF_OFF_INTCTL:  nxt_prdata[7:0] = intctl_ff;
                `CIEF_OFF_PERIPH_EN: nxt_prdata[7:0] = periph_en_ff;
                `CIEF_OFF_PFLAG:   nxt_prdata[7:0] = periph_flags;
                `CIEF_OFF_EDGESEL: nxt_prdata[0]   = edgesel_ff;
                `CIEF_OFF_PCPINS:  nxt_prdata[PORT_W-1:0] = pcpins_ff;
                `CIEF_OFF_ISTAT:   nxt_prdata[`CIEF_ST_W-1:0] = istat_ff;
                `CIEF_OFF_IENA:    nxt_prdata[`CIEF_ST_W-1:0] = iena_ff;
                `CIEF_OFF_VECTOR:  nxt_prdata[12:0] = irq_vector;
                default:           nxt_prdata = `CIEF_APB_ZERO;
            endcase
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Port change flag is left as-is at reset: its power-on value is undefined
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            intctl_ff[7:1] <= 7'(`CIEF_RST_INTCTL >> 1);
            intctl_ff[0]   <= nxt_intctl[0];
            periph_en_ff   <= `CIEF_RST_PERIPH_EN;
            edgesel_ff     <= 1'b0;
            pcpins_ff      <= '0;
            iena_ff        <= '0;
            istat_ff       <= '0;
            prdata_ff      <= `CIEF_APB_ZERO;
            pslverr_ff     <= 1'b0;
        end
        else
        begin
            intctl_ff      <= nxt_intctl;
            periph_en_ff   <= nxt_periph_en;
            edgesel_ff     <= nxt_edgesel;
            pcpins_ff      <= nxt_pcpins;
            iena_ff        <= nxt_iena;
            istat_ff       <= nxt_istat;
            prdata_ff      <= nxt_prdata;
            pslverr_ff     <= nxt_pslverr;
        end
    end

endmodule : cief_core_irq

/* tb/cief_core_irq_asserts.sv */
// Port-level checks of the interrupt enable and flag block
module cief_core_irq_asserts (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  periph_flags,
    input wire logic        irq_ack,
    input wire logic        core_irq_req,
    input wire logic        irq_taken,
    input wire logic [12:0] irq_vector,
    input wire logic        irq
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Completed write; the only software path that may drop a request
    logic wr_acc;
    assign wr_acc = psel && penable && pwrite;
    property p_vec; irq_vector == 13'h0004; endproperty
    a_vec: assert property (p_vec) else $error("vector wrong");
    property p_take; irq_taken == (core_irq_req && irq_ack); endproperty
    a_take: assert property (p_take) else $error("taken wrong");
    property p_gie_off; irq_taken && !wr_acc |=> !core_irq_req; endproperty
    a_gie_off: assert property (p_gie_off) else $error("request kept");
    property p_req_fall; $fell(core_irq_req) |-> $past(irq_taken || wr_acc) || $changed(periph_flags);
    endproperty
    a_req_fall: assert property (p_req_fall) else $error("request fell alone");
    property p_irq_fall; $fell(irq) |-> $past(wr_acc); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
    property p_rst; disable iff (1'b0) reset |=> !core_irq_req && !irq && !pslverr; endproperty
    a_rst: assert property (p_rst) else $error("not idle after reset");
    property p_rdy; psel |-> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
    property p_err; pslverr |-> $past(psel && penable); endproperty
    a_err: assert property (p_err) else $error("stray error");
    c_take: cover property (irq_taken);
    c_err: cover property (pslverr);
    c_irq: cover property ($rose(irq));
endmodule : cief_core_irq_asserts

bind cief_core_irq cief_core_irq_asserts cief_core_irq_asserts_i (.clk, .reset, .psel, .penable,
    .pwrite, .pready, .pslverr, .periph_flags, .irq_ack, .core_irq_req, .irq_taken, .irq_vector,
    .irq);

/* tb/cief_core_model.sv */
// Behavioural processor core that accepts the combined request
module cief_core_model (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       core_irq_req,
    input  wire logic       ack_en,
    input  wire logic [3:0] ack_delay,
    output logic            irq_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_cnt;
    // Acknowledge ack_delay+1 cycles after the request rises; a slow core leaves the request standing
    always @(posedge clk)
    begin
        if (reset || !core_irq_req || !ack_en)
        begin
            wait_cnt <= 4'h0;
            irq_ack  <= 1'b0;
        end
        else
        begin
            wait_cnt <= wait_cnt + 4'h1;
            irq_ack  <= (wait_cnt == ack_delay);
        end
    end
endmodule : cief_core_model

/* tb/test_core_interrupt_enable_flags.sv */
// Self-checking bench for the interrupt enable and flag block
module test_core_interrupt_enable_flags;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, reset, psel, penable, pwrite, pready, pslverr, timer_rollover, ext_pin;
    logic        irq_ack, core_irq_req, irq_taken, irq, ack_en;
    logic        acc_seen = 1'b0;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [12:0] irq_vector;
    logic [7:0]  port_pins, periph_flags, bit_m, m;
    logic [3:0]  ack_delay;
    logic [33:0] notes[$];
    int          fails, total_checks;

    cief_core_irq #(.PORT_W(8)) cief_core_irq_i (.clk, .reset, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .timer_rollover, .ext_pin, .port_pins, .periph_flags,
        .irq_ack, .core_irq_req, .irq_taken, .irq_vector, .irq);
    cief_core_model cief_core_model_i (.clk, .reset, .core_irq_req, .ack_en, .ack_delay, .irq_ack);

    // ****
    // Helpers
    // ****
    always #10 clk = ~clk;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    // One APB transfer; the note is judged when its result shows
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic err, input logic [31:0] exp);
        notes.push_back({w, err, exp});
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, 1'b0, 32'h0);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0, 1'b0, {24'h0, e});
    endtask : rd
    // Outputs are settled by the falling edge
    task automatic see(input logic er, input logic ei);
        @(negedge clk);
        chk("core_irq_req", {31'h0, er}, {31'h0, core_irq_req});
        chk("irq", {31'h0, ei}, {31'h0, irq});
        @(posedge clk);
    endtask : see
    task automatic pulse();
        timer_rollover <= 1'b1;
        @(posedge clk);
        timer_rollover <= 1'b0;
        @(posedge clk);
    endtask : pulse
    task automatic ev(input logic e, input logic [7:0] p, input logic [7:0] x);
        ext_pin   <= e;
        port_pins <= p;
        repeat (3) @(posedge clk);
        rd(12'h000, x);
    endtask : ev
    task automatic final_report();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    // Read data and error land one cycle after the completing edge
    always @(posedge clk)
    begin
        acc_seen <= psel && penable && pready;
        if (acc_seen)
        begin
            chk("pslverr", {31'h0, notes[0][32]}, {31'h0, pslverr});
            if (!notes[0][33])
                chk("prdata", notes[0][31:0], prdata);
            void'(notes.pop_front());
        end
    end
    // About sixty-five times the expected run length
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        final_report();
    end

    // ****
    // Scenarios
    // ****
    initial
    begin
        {clk, psel, penable, pwrite, timer_rollover, ack_en} = '0;
        {paddr, pwdata, port_pins, periph_flags, ack_delay} = '0;
        reset   = 1'b1;
        ext_pin = 1'b1;
        bit_m   = 8'($urandom(75608));
        m       = 8'h01 << bit_m[2:0];
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        see(1'b0, 1'b0);
        rd(12'h004, 8'h00);
        wr(12'h01c, 8'h0f);
        wr(12'h000, 8'h00);
        rd(12'h000, 8'h00);
        wr(12'h004, bit_m);
        rd(12'h004, bit_m);
        pulse();
        ev(1'b0, 8'h00, 8'h06);
        wr(12'h000, 8'h00);
        ev(1'b1, 8'h00, 8'h00);
        wr(12'h00c, 8'h01);
        ev(1'b0, 8'h00, 8'h00);
        ev(1'b1, 8'h00, 8'h02);
        wr(12'h010, m);
        ev(1'b1, ~m, 8'h02);
        ev(1'b1, 8'hff, 8'h03);
        // Each core source with its enable set needs its flag and the global enable
        for (int i = 0; i < 3; i++)
        begin
            wr(12'h000, (8'h20 >> i) | (8'h04 >> i));
            see(1'b0, 1'b0);
            wr(12'h000, 8'h80 | (8'h20 >> i) | (8'h04 >> i));
            see(1'b1, 1'b0);
            wr(12'h000, 8'h80 | (8'h20 >> i) | (8'h07 & ~(8'h04 >> i)));
            see(1'b0, 1'b0);
        end
        // Peripheral pairs under the group enable
        for (int i = 0; i < 8; i++)
        begin
            periph_flags <= 8'h01 << i;
            wr(12'h004, 8'h01 << i);
            wr(12'h000, 8'h80);
            see(1'b0, 1'b0);
            wr(12'h000, 8'hc0);
            see(1'b1, 1'b0);
            wr(12'h004, ~(8'h01 << i));
            see(1'b0, 1'b0);
        end
        rd(12'h008, 8'h80);
        // Prompt and slow acceptance by the core
        wr(12'h004, 8'hff);
        ack_en <= 1'b1;
        for (int d = 0; d < 2; d++)
        begin
            ack_delay <= 4'(d * 5);
            wr(12'h000, 8'hc0);
            repeat (10) @(posedge clk);
            rd(12'h000, 8'h40);
        end
        ack_en <= 1'b0;
        rd(12'h014, 8'h0f);
        wr(12'h01c, 8'h0f);
        rd(12'h014, 8'h00);
        wr(12'h018, 8'h08);
        pulse();
        see(1'b0, 1'b1);
        wr(12'h018, 8'h00);
        see(1'b0, 1'b0);
        wr(12'h018, 8'h08);
        see(1'b0, 1'b1);
        wr(12'h01c, 8'h08);
        see(1'b0, 1'b0);
        apb(1'b0, 12'h040, 32'h0, 1'b1, 32'h0);
        apb(1'b1, 12'h044, 32'hffff_ffff, 1'b1, 32'h0);
        repeat (2) @(posedge clk);
        final_report();
    end
endmodule : test_core_interrupt_enable_flags
